// [sim/interrupt_status_one_bus_model.sv]
`timescale 1ns/10ps
`default_nettype none
module interrupt_status_one_bus_model (
    // Clock and holdoff
    input wire logic i_clk,
    input wire logic i_dac_hold,
    // Acceptor state and byte class
    output logic o_acds,
    output logic [7:0] o_byte,
    output logic [4:0] o_cls,
    output logic o_defined,
    output logic [3:0] o_state
);
    initial begin
        o_acds = 1'b0;
        o_byte = 8'h00;
        o_cls = 5'h00;
        o_defined = 1'b0;
        o_state = 4'h0;
    end
    task automatic accept(input logic [4:0] c, input logic d, input logic [3:0] s);
        o_byte = {3'h0, c};
        o_cls = c;
        o_defined = d;
        o_state = s;
        @(negedge i_clk);
        o_acds = 1'b1;
        @(negedge i_clk);
    endtask
    task automatic release_bus();
        for (int n = 0; n < 10 && i_dac_hold; n++) begin
            @(negedge i_clk);
        end
        o_acds = 1'b0;
        o_byte = ~o_byte;
        @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// [sim/interrupt_status_one_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module interrupt_status_one_monitor
    import interrupt_status_one_pkg::*;
(
    // Watched ports
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic [2:0] I_ADDR,
    input wire logic I_RD,
    input wire logic I_WR,
    input wire logic [7:0] I_WDATA,
    input wire logic [7:0] O_RDATA,
    input wire logic O_IRQ,
    input wire logic I_ACDS,
    input wire logic I_ACG,
    input wire logic I_SCG,
    input wire logic I_CMD_DECODED,
    input wire logic I_TADS,
    input wire logic I_LADS,
    input wire logic [5:0] I_EVENTS,
    input wire logic O_DAC_HOLD
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    a_hold_release: assert property ($rose(I_WR) && I_ADDR == OFS_AUX &&
        I_WDATA == AUX_CMD_VALID |-> ##[1:3] !O_DAC_HOLD) else $error("hold kept after valid");
    a_hold_drop_cause: assert property ($fell(O_DAC_HOLD) |-> $past(I_WR) ||
        $past(I_WR, 2) || $past(I_WR, 3)) else $error("hold dropped without write");
    a_hold_on_accept: assert property ($rose(O_DAC_HOLD) |-> $past(I_ACDS) &&
        !$past(I_ACDS, 2)) else $error("hold raised without accept");
    a_irq_fall_cause: assert property ($fell(O_IRQ) |-> $past(I_RD, 2) ||
        $past(I_RD, 3) || $past(I_RD, 4) || $past(I_RD, 5) || $past(I_WR, 2) ||
        $past(I_WR, 3)) else $error("irq fell without read or mask write");
    a_rdata_on_read: assert property (!$stable(O_RDATA) |-> $past(I_RD))
        else $error("read data changed outside read");
    a_event_kept: assert property ((I_EVENTS != 6'h00 && !I_RD) ##1
        (I_RD && I_ADDR == OFS_STATUS_ONE) |=>
        ((O_RDATA[5:0] & $past(I_EVENTS, 2)) == $past(I_EVENTS, 2)))
        else $error("event missing from read");
    a_unaddr_ignored: assert property ($rose(I_ACDS) && I_ACG && !I_TADS &&
        !I_LADS && !O_DAC_HOLD |=> !O_DAC_HOLD) else $error("unaddressed command held");
    a_defined_free: assert property ($rose(I_ACDS) && I_CMD_DECODED && !I_SCG &&
        !O_DAC_HOLD |=> !O_DAC_HOLD) else $error("defined command held");
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
    import interrupt_status_one_pkg::*;
    logic I_CORE_CLK = 1'b0, I_NRST = 1'b0, I_RD = 1'b0, I_WR = 1'b0;
    logic [2:0] I_ADDR = 3'h0;
    logic [7:0] I_WDATA = 8'h00;
    logic [5:0] I_EVENTS = 6'h00;
    logic [7:0] O_RDATA, cbyte;
    logic O_IRQ, O_DAC_HOLD, acds, dec;
    logic [4:0] cls;
    logic [3:0] st;
    int failures = 0, comparisons = 0;
    always #25 I_CORE_CLK = ~I_CORE_CLK;
    interrupt_status_one_top interrupt_status_one_top_inst (.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR),
        .I_RD(I_RD), .I_WR(I_WR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ),
        .I_ACDS(acds), .I_CMD_BYTE(cbyte), .I_UCG(cls[4]), .I_ACG(cls[3]), .I_SCG(cls[2]),
        .I_TAG(cls[1]), .I_LAG(cls[0]), .I_CMD_DECODED(dec), .I_TADS(st[3]), .I_LADS(st[2]),
        .I_TPAS(st[1]), .I_LPAS(st[0]), .I_EVENTS(I_EVENTS), .O_DAC_HOLD(O_DAC_HOLD));
    interrupt_status_one_bus_model interrupt_status_one_bus_model_inst (.i_clk(I_CORE_CLK), .i_dac_hold(O_DAC_HOLD),
        .o_acds(acds), .o_byte(cbyte), .o_cls(cls), .o_defined(dec), .o_state(st));
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        I_ADDR = a;
        I_WDATA = d;
        I_WR = 1'b1;
        @(negedge I_CORE_CLK);
        I_WR = 1'b0;
        @(negedge I_CORE_CLK);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        I_ADDR = a;
        I_RD = 1'b1;
        repeat (2) @(negedge I_CORE_CLK);
        d = O_RDATA;
        I_RD = 1'b0;
        repeat (2) @(negedge I_CORE_CLK);
    endtask
    task automatic flags(input logic [7:0] e);
        logic [7:0] v;
        rd(OFS_STATUS_ONE, v);
        `CHK("flags", e, v)
    endtask
    task automatic pulse(input logic [5:0] e);
        I_EVENTS = e;
        @(negedge I_CORE_CLK);
        I_EVENTS = 6'h00;
    endtask
    task automatic cmd(input logic [4:0] c, input logic d, input logic [3:0] s,
        input logic h, input logic [7:0] rel, input logic i, input logic [7:0] f);
        logic [7:0] v;
        logic [7:0] pb;
        pb = {3'h0, c};
        interrupt_status_one_bus_model_inst.accept(c, d, s);
        repeat (2) @(negedge I_CORE_CLK);
        `CHK("dac_hold", h, O_DAC_HOLD)
        `CHK("irq", i, O_IRQ)
        if (h) begin
            rd(OFS_AUX, v);
            `CHK("pt_byte", pb, v)
            wr(OFS_AUX, rel);
        end
        interrupt_status_one_bus_model_inst.release_bus();
        flags(f);
    endtask
    task automatic t_events();
        flags(8'h00);
        wr(OFS_STATUS_ONE, 8'h01);
        pulse(6'h3F);
        @(negedge I_CORE_CLK);
        `CHK("irq", 1'b1, O_IRQ)
        flags(8'h3F);
        @(negedge I_CORE_CLK);
        `CHK("irq", 1'b0, O_IRQ)
        pulse(6'h04);
        @(negedge I_CORE_CLK);
        `CHK("irq", 1'b0, O_IRQ)
        flags(8'h04);
        pulse(6'h02);
        flags(8'h02);
        $display("events test done");
    endtask
    task automatic t_holdoff();
        logic [7:0] v;
        I_ADDR = OFS_STATUS_ONE;
        I_RD = 1'b1;
        @(negedge I_CORE_CLK);
        I_EVENTS = 6'h08;
        @(negedge I_CORE_CLK);
        v = O_RDATA;
        I_EVENTS = 6'h00;
        I_RD = 1'b0;
        repeat (2) @(negedge I_CORE_CLK);
        `CHK("read_value", 8'h00, v)
        flags(8'h08);
        I_ADDR = OFS_STATUS_ONE;
        I_RD = 1'b1;
        I_EVENTS = 6'h10;
        @(negedge I_CORE_CLK);
        I_EVENTS = 6'h00;
        @(negedge I_CORE_CLK);
        v = O_RDATA;
        I_RD = 1'b0;
        repeat (2) @(negedge I_CORE_CLK);
        `CHK("read_value", 8'h00, v)
        flags(8'h10);
        $display("holdoff test done");
    endtask
    task automatic t_pass();
        wr(OFS_AUX, 8'hA1);
        wr(OFS_STATUS_ONE, 8'h80);
        cmd(5'h10, 1'b0, 4'h0, 1'b1, AUX_CMD_VALID, 1'b1, 8'h80);
        cmd(5'h04, 1'b0, 4'h0, 1'b1, AUX_CMD_VALID, 1'b1, 8'h80);
        cmd(5'h10, 1'b1, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
        cmd(5'h04, 1'b0, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
        cmd(5'h08, 1'b0, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
        cmd(5'h08, 1'b0, 4'h8, 1'b1, AUX_CMD_VALID, 1'b1, 8'h80);
        cmd(5'h02, 1'b0, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
        cmd(5'h04, 1'b0, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
        cmd(5'h10, 1'b0, 4'h0, 1'b1, AUX_CMD_VALID, 1'b1, 8'h80);
        cmd(5'h01, 1'b0, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
        cmd(5'h04, 1'b0, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
        wr(OFS_AUX, 8'hA0);
        cmd(5'h10, 1'b0, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
        wr(OFS_ADDR_MODE, 8'h03);
        wr(OFS_STATUS_ONE, 8'h40);
        cmd(5'h04, 1'b0, 4'h2, 1'b1, AUX_CMD_NONVALID, 1'b1, 8'h40);
        cmd(5'h04, 1'b0, 4'h1, 1'b1, AUX_CMD_VALID, 1'b1, 8'h40);
        $display("pass-through test done");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge I_CORE_CLK);
        I_NRST = 1'b1;
        repeat (3) @(negedge I_CORE_CLK);
        t_events();
        t_holdoff();
        t_pass();
        print_verdict();
    end
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
endmodule
bind interrupt_status_one_top interrupt_status_one_monitor interrupt_status_one_monitor_inst (.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST),
    .I_ADDR(I_ADDR), .I_RD(I_RD), .I_WR(I_WR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA),
    .O_IRQ(O_IRQ), .I_ACDS(I_ACDS), .I_ACG(I_ACG), .I_SCG(I_SCG),
    .I_CMD_DECODED(I_CMD_DECODED), .I_TADS(I_TADS), .I_LADS(I_LADS),
    .I_EVENTS(I_EVENTS), .O_DAC_HOLD(O_DAC_HOLD));
`default_nettype wire

// [verilog/interrupt_status_one_flag_cell.sv]
`timescale 1ns/10ps
`default_nettype none
module interrupt_status_one_flag_cell (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Event and read control
    input wire logic i_set,
    input wire logic i_rd_busy,
    input wire logic i_rd_end,
    // Flag
    output logic o_flag
);
    logic flag_q;
    logic pend_q;

    // RULE5: hold during read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else if (i_rd_end) begin
            pend_q <= 1'b0;
        end else if (i_rd_busy && i_set) begin
            pend_q <= 1'b1;
        end
    end

    // RULE1: clear after read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (i_rd_end) begin
            flag_q <= pend_q | i_set;
        end else if (!i_rd_busy && (i_set || pend_q)) begin
            flag_q <= 1'b1;
        end
    end

    assign o_flag = flag_q;
endmodule
`default_nettype wire

// [verilog/interrupt_status_one_pkg.sv]
package interrupt_status_one_pkg;
    // Host I/O offsets
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_STATUS_ONE = 3'h1;
    localparam logic [2:0] OFS_ADDR_MODE = 3'h4;
    localparam logic [2:0] OFS_AUX = 3'h5;
    // Flag byte and config B bit positions
    localparam int BIT_CPT = 7;
    localparam int BIT_APT = 6;
    localparam int BIT_PT_ON = 0;
    // Write field positions
    localparam int AUX_CODE_HI = 7;
    localparam int AUX_CODE_LO = 5;
    localparam int CFG_B_HI = 4;
    localparam int MODE_HI = 1;
    localparam int EVT_HI = 5;
    // Auxiliary command and address mode encoding
    localparam logic [2:0] AUX_CTRL_CFG_B = 3'h5;
    localparam logic [7:0] AUX_CMD_VALID = 8'h0F;
    localparam logic [7:0] AUX_CMD_NONVALID = 8'h07;
    localparam logic [1:0] ADDR_MODE_PASS = 2'h3;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] RST_CFG_B = 5'h00;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [1:0] RST_SYNC = 2'h0;
endpackage

// [verilog/interrupt_status_one_top.sv]
//
// Functional notes
// RULE1: Flag byte read at offset 1; reading clears set flags.
// RULE2: Write-only enable byte at offset 1, bits matching flags.
// RULE3: Enabled event raises interrupt request.
// RULE4: Flags set and clear regardless of enable bits.
// RULE5: Event during a flag read is applied after the read ends.
// RULE6: Command pass-through flag and enable sit in bit 7.
// RULE7: Pass-through flag set on undefined command or following secondaries.
// RULE8: Latch set on accepted undefined universal or addressed command.
// RULE9: Latch cleared on reset, feature off, defined command or address.
// RULE10: Pass-through feature on only while config B bit 0 set.
// RULE11: Commands not decoded here count as undefined.
// RULE12: Addressed command ignored when neither talker nor listener.
// RULE13: Passed command stalls handshake until valid command 0F written.
// RULE14: Feature off: undefined commands ignored, handshake completes.
// RULE15: Address pass-through flag on secondary in TPAS or LPAS, mode 3.
// RULE16: Host checks address flag and reads the secondary address.
// RULE17: Address flag pending holds DAC until valid or non-valid.
// RULE18: Request is OR of flag AND enable; all clear on reset.
// RULE19: Read data captured before flags clear.
//
`timescale 1ns/10ps
`default_nettype none
module interrupt_status_one_top
    import interrupt_status_one_pkg::*;
#(
    parameter int N_FLAGS = 8
) (
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    // Host I/O bus
    input wire logic [2:0] I_ADDR,
    input wire logic I_RD,
    input wire logic I_WR,
    input wire logic [7:0] I_WDATA,
    output logic [7:0] O_RDATA,
    output logic O_IRQ,
    // Bus acceptor state and command decode
    input wire logic I_ACDS,
    input wire logic [7:0] I_CMD_BYTE,
    input wire logic I_UCG,
    input wire logic I_ACG,
    input wire logic I_SCG,
    input wire logic I_TAG,
    input wire logic I_LAG,
    input wire logic I_CMD_DECODED,
    input wire logic I_TADS,
    input wire logic I_LADS,
    input wire logic I_TPAS,
    input wire logic I_LPAS,
    // Other flag events, bits 5 to 0
    input wire logic [5:0] I_EVENTS,
    // Handshake holdoff
    output logic O_DAC_HOLD
);
    import interrupt_status_one_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_sync_q <= RST_SYNC;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ****************************************
    // Host access strobes
    // ****************************************
    logic rd_status;
    logic rd_status_q;
    logic rd_start;
    logic rd_end;
    logic wr_q;
    logic wr_take;

    assign rd_status = I_RD && (I_ADDR == OFS_STATUS_ONE);
    assign rd_start = rd_status && !rd_status_q;
    assign rd_end = rd_status_q && !rd_status;
    assign wr_take = I_WR && !wr_q;

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_status_q <= 1'b0;
        end else begin
            rd_status_q <= rd_status;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= I_WR;
        end
    end

    // ****************************************
    // Host write decode
    // ****************************************
    logic wr_mask;
    logic wr_mode;
    logic wr_aux;
    logic wr_cfg_b;

    // RULE2: mask write decode
    always_comb begin
        wr_mask = 1'b0;
        wr_mode = 1'b0;
        wr_aux = 1'b0;
        if (!wr_take) begin
            wr_mask = 1'b0;
        end else if (I_ADDR == OFS_STATUS_ONE) begin
            wr_mask = 1'b1;
        end else if (I_ADDR == OFS_ADDR_MODE) begin
            wr_mode = 1'b1;
        end else if (I_ADDR == OFS_AUX) begin
            wr_aux = 1'b1;
        end
    end

    assign wr_cfg_b = wr_aux &&
                      (I_WDATA[AUX_CODE_HI:AUX_CODE_LO] == AUX_CTRL_CFG_B);

    // ****************************************
    // Writable registers
    // ****************************************
    logic [7:0] interrupt_mask_one_q;
    logic [4:0] aux_config_b_q;
    logic [1:0] addr_mode_q;
    logic passthrough_feature_on;
    logic aux_valid_wr;
    logic aux_nonvalid_wr;

    // RULE2: enable byte write
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_mask_one_q <= RST_BYTE;
        end else if (wr_mask) begin
            interrupt_mask_one_q <= I_WDATA;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            aux_config_b_q <= RST_CFG_B;
        end else if (wr_cfg_b) begin
            aux_config_b_q <= I_WDATA[CFG_B_HI:0];
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            addr_mode_q <= RST_MODE;
        end else if (wr_mode) begin
            addr_mode_q <= I_WDATA[MODE_HI:0];
        end
    end

    // RULE10: feature from config B bit 0
    assign passthrough_feature_on = aux_config_b_q[BIT_PT_ON];

    assign aux_valid_wr = wr_aux && (I_WDATA == AUX_CMD_VALID);
    assign aux_nonvalid_wr = wr_aux && (I_WDATA == AUX_CMD_NONVALID);

    // ****************************************
    // Command acceptance
    // ****************************************
    logic acds_q;
    logic accept;
    logic cmd_undefined;
    logic cmd_addressed_ok;
    logic cmd_passable;
    logic undefined_command_latch_q;
    logic cpt_set;
    logic apt_set;

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            acds_q <= 1'b0;
        end else begin
            acds_q <= I_ACDS;
        end
    end

    assign accept = I_ACDS && !acds_q;

    // RULE11: not decoded means undefined
    assign cmd_undefined = !I_CMD_DECODED;

    // RULE12: addressed needs talker or listener
    assign cmd_addressed_ok = I_ACG && (I_TADS || I_LADS);

    assign cmd_passable = (I_UCG || cmd_addressed_ok) && cmd_undefined;

    // RULE8: latch set on undefined
    // RULE9: latch clear conditions
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            undefined_command_latch_q <= 1'b0;
        end else if (!passthrough_feature_on) begin
            undefined_command_latch_q <= 1'b0;
        end else if (accept && cmd_passable) begin
            undefined_command_latch_q <= 1'b1;
        end else if (accept && (((I_UCG || I_ACG) && !cmd_undefined) || I_TAG || I_LAG)) begin
            undefined_command_latch_q <= 1'b0;
        end
    end

    // RULE7: command pass-through set
    // RULE14: no command passed while feature off
    assign cpt_set = accept && passthrough_feature_on &&
                     (cmd_passable || (undefined_command_latch_q && I_SCG));

    // RULE15: address pass-through set
    assign apt_set = accept && (addr_mode_q == ADDR_MODE_PASS) &&
                     (I_TPAS || I_LPAS) && I_SCG;

    // ****************************************
    // Pass-through byte and holdoff
    // ****************************************
    logic [7:0] passthrough_byte_reg_q;
    logic cpt_hold_q;
    logic apt_hold_q;
    logic dac_hold_q;

    // RULE16: secondary address kept for host
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            passthrough_byte_reg_q <= RST_BYTE;
        end else if (cpt_set || apt_set) begin
            passthrough_byte_reg_q <= I_CMD_BYTE;
        end
    end

    // RULE13: stall until valid command
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cpt_hold_q <= 1'b0;
        end else if (cpt_set) begin
            cpt_hold_q <= 1'b1;
        end else if (aux_valid_wr) begin
            cpt_hold_q <= 1'b0;
        end
    end

    // RULE17: hold until valid or non-valid
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            apt_hold_q <= 1'b0;
        end else if (apt_set) begin
            apt_hold_q <= 1'b1;
        end else if (aux_valid_wr || aux_nonvalid_wr) begin
            apt_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            dac_hold_q <= 1'b0;
        end else begin
            dac_hold_q <= cpt_hold_q || apt_hold_q || cpt_set || apt_set;
        end
    end

    assign O_DAC_HOLD = dac_hold_q;

    // ****************************************
    // Event flags
    // ****************************************
    logic [N_FLAGS-1:0] flag_set;
    logic [N_FLAGS-1:0] interrupt_status_one;

    // RULE6: pass-through flag in bit 7
    always_comb begin
        flag_set = '0;
        flag_set[EVT_HI:0] = I_EVENTS;
        flag_set[BIT_APT] = apt_set;
        flag_set[BIT_CPT] = cpt_set;
    end

    // RULE4: flags independent of enables
    for (genvar g = 0; g < N_FLAGS; g++) begin : g_flag
        interrupt_status_one_flag_cell u_cell (
            .clk(I_CORE_CLK),
            .rst_n(rst_n),
            .i_set(flag_set[g]),
            .i_rd_busy(rd_status),
            .i_rd_end(rd_end),
            .o_flag(interrupt_status_one[g])
        );
    end

    // ****************************************
    // Read data
    // ****************************************
    logic [7:0] rdata_q;

    // RULE19: capture before clear
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= RST_BYTE;
        end else if (rd_start) begin
            rdata_q <= interrupt_status_one;
        end else if (I_RD && !rd_status) begin
            if (I_ADDR == OFS_AUX) begin
                rdata_q <= passthrough_byte_reg_q;
            end else begin
                rdata_q <= RST_BYTE;
            end
        end
    end

    assign O_RDATA = rdata_q;

    // ****************************************
    // Interrupt request
    // ****************************************
    logic irq_q;

    // RULE3: enabled event requests
    // RULE18: OR of flag AND enable
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(interrupt_status_one & interrupt_mask_one_q);
        end
    end

    assign O_IRQ = irq_q;
endmodule
`default_nettype wire
